// ### rtl/iopim_mapper.sv
// Process image mapper: channel states to and from cyclic process bytes
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module iopim_mapper #(
  parameter bit HAS_EXT = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [iopim_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [iopim_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [iopim_pkg::DATA_W-1:0] reg_rdata,
  // Physical channel states (from pins)
  input wire logic [iopim_pkg::NUM_CONN-1:0] pin4_channel_states,
  input wire logic [iopim_pkg::NUM_CONN-1:0] pin2_channel_states,
  // Channel targets to drivers
  output logic [iopim_pkg::NUM_CONN-1:0] pin4_target_states,
  output logic [iopim_pkg::NUM_CONN-1:0] pin2_target_states,
  // Cyclic image from controller, and to controller
  input wire iopim_pkg::iopim_image_out_t image_out,
  output iopim_pkg::iopim_image_in_t image_in,
  // Extension side
  input wire logic [15:0] ext_bits_from_ext,
  input wire logic [iopim_pkg::EXT_WORDS*iopim_pkg::WORD_W-1:0] ext_words_from_ext,
  output logic [15:0] ext_bits_to_ext,
  output logic [iopim_pkg::EXT_WORDS*iopim_pkg::WORD_W-1:0] ext_words_to_ext,
  // Status
  output logic map_fault
);

  // ****************************************************************
  // State
  // ****************************************************************
  localparam int unsigned NUM_CH = 16;

  typedef struct packed {
    logic [iopim_pkg::NUM_CONN-1:0] s4a;
    logic [iopim_pkg::NUM_CONN-1:0] s4b;
    logic [iopim_pkg::NUM_CONN-1:0] s2a;
    logic [iopim_pkg::NUM_CONN-1:0] s2b;
    iopim_pkg::iopim_profile_t profile;
    iopim_pkg::iopim_state_t state;
    logic remap_en;
    logic [NUM_CH*4-1:0] map;
    logic fault;
    logic [iopim_pkg::DATA_W-1:0] rdata;
    logic [7:0] tgt4;
    logic [7:0] tgt2;
    iopim_pkg::iopim_image_in_t img;
    logic [15:0] xbits;
    logic [iopim_pkg::EXT_WORDS*iopim_pkg::WORD_W-1:0] xwords;
  } iopim_regs_t;

  iopim_regs_t r_q;
  iopim_regs_t r_d;

  // ****************************************************************
  // Default sequential layout and optional remap
  // ****************************************************************
  logic [15:0] phys_seq;
  logic [15:0] log_in;
  logic [15:0] out_seq;
  logic [15:0] dup_hit;

  always_comb begin
    for (int c = 0; c < 8; c++) begin
      phys_seq[2*c] = r_q.s4b[c];
      phys_seq[2*c+1] = r_q.s2b[c];
    end
  end

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_map
      logic [3:0] sel;
      assign sel = r_q.map[g*4 +: 4];
      assign log_in[g] = r_q.remap_en ? phys_seq[sel] : phys_seq[g];
      assign out_seq[g] = r_q.remap_en ?
        image_out.out_bytes[sel] : image_out.out_bytes[g];
      logic hit;
      always_comb begin
        hit = 1'b0;
        for (int j = 0; j < 16; j++) begin
          if (j != g && r_q.map[j*4 +: 4] == sel) begin
            hit = 1'b1;
          end
        end
      end
      assign dup_hit[g] = hit;
    end
  endgenerate

  // ****************************************************************
  // Register decode
  // ****************************************************************
  logic in_config;
  logic in_cyclic;
  logic ctrl_wr;
  logic run_entry;
  logic run_exit;
  logic map_hit;
  logic [3:0] map_idx;

  assign in_config = r_q.state == iopim_pkg::iopim_st_config;
  assign in_cyclic = r_q.state == iopim_pkg::iopim_st_cyclic;
  assign ctrl_wr = reg_wr && reg_addr == iopim_pkg::REG_CTRL;
  assign run_entry = ctrl_wr && in_config &&
    reg_wdata[iopim_pkg::CTRL_RUN_BIT];
  assign run_exit = ctrl_wr && !reg_wdata[iopim_pkg::CTRL_RUN_BIT];
  assign map_hit = reg_addr >= iopim_pkg::REG_MAP_BASE &&
    reg_addr < iopim_pkg::REG_MAP_BASE + 8'h10;
  assign map_idx = reg_addr[3:0];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [7:0] t4;
    logic [7:0] t2;
    logic [15:0] ib;
    t4 = 8'h00;
    t2 = 8'h00;
    ib = 16'h0000;
    r_d = r_q;

    // ****************************************************************
    // Pin synchroniser, two stages
    // ****************************************************************
    r_d.s4a = pin4_channel_states;
    r_d.s4b = r_q.s4a;
    r_d.s2a = pin2_channel_states;
    r_d.s2b = r_q.s2a;

    // ****************************************************************
    // Profile mapping
    // ****************************************************************
    if (in_cyclic) begin
      case (r_q.profile)
        iopim_pkg::sixteen_mixed_profile: begin
          ib = log_in;
          for (int c = 0; c < 8; c++) begin
            t4[c] = out_seq[2*c];
            t2[c] = out_seq[2*c+1];
          end
        end
        iopim_pkg::eight_mixed_profile: begin
          ib = {8'h00, r_q.s4b};
          t4 = image_out.out_bytes[7:0];
        end
        iopim_pkg::sixteen_input_profile: begin
          ib = log_in;
        end
        iopim_pkg::eight_input_profile: begin
          ib = {8'h00, r_q.s4b};
        end
        iopim_pkg::sixteen_output_profile: begin
          ib = log_in;
          for (int c = 0; c < 8; c++) begin
            t4[c] = out_seq[2*c];
            t2[c] = out_seq[2*c+1];
          end
        end
        iopim_pkg::eight_output_profile: begin
          t4 = image_out.out_bytes[7:0];
        end
        iopim_pkg::split_in_out_profile: begin
          ib = {8'h00, log_in[7:0]};
          for (int c = 0; c < 4; c++) begin
            t4[c+4] = image_out.out_bytes[2*c];
            t2[c+4] = image_out.out_bytes[2*c+1];
          end
        end
        default: begin
          ib = 16'h0000;
        end
      endcase

      // **************************************************************
      // Targets held off while the map is faulty
      // **************************************************************
      if (r_q.fault) begin
        t4 = 8'h00;
        t2 = 8'h00;
      end
    end
    r_d.tgt4 = t4;
    r_d.tgt2 = t2;
    r_d.img.in_bytes = ib;

    // ****************************************************************
    // Extension pass-through
    // ****************************************************************
    if (HAS_EXT) begin
      r_d.img.ext_bits_in = ext_bits_from_ext;
      r_d.img.ext_words_in = ext_words_from_ext;
      r_d.xbits = image_out.ext_bits_out;
      r_d.xwords = image_out.ext_words_out;
    end else begin
      r_d.img.ext_bits_in = '0;
      r_d.img.ext_words_in = '0;
      r_d.xbits = '0;
      r_d.xwords = '0;
    end

    // ****************************************************************
    // Register writes, profile and map locked while running
    // ****************************************************************
    case (r_q.state)
      iopim_pkg::iopim_st_config: begin
        if (ctrl_wr) begin
          r_d.profile = iopim_pkg::iopim_profile_t'(
            reg_wdata[iopim_pkg::CTRL_PROF_LSB +: 3]);
          r_d.remap_en = reg_wdata[iopim_pkg::CTRL_REMAP_BIT];
        end
        if (run_entry) begin
          r_d.state = iopim_pkg::iopim_st_cyclic;
          r_d.fault = r_d.remap_en && (|dup_hit);
        end
        if (reg_wr && map_hit) begin
          r_d.map[map_idx*4 +: 4] = reg_wdata[3:0];
        end
      end
      iopim_pkg::iopim_st_cyclic: begin
        if (run_exit) begin
          r_d.state = iopim_pkg::iopim_st_config;
        end
      end
      default: begin
        r_d.state = iopim_pkg::iopim_st_config;
      end
    endcase

    // ****************************************************************
    // Register reads, data stand one cycle
    // ****************************************************************
    r_d.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        iopim_pkg::REG_CTRL: begin
          r_d.rdata = {11'h000, in_cyclic, r_q.remap_en, r_q.profile};
        end
        iopim_pkg::REG_STATUS: begin
          r_d.rdata = {15'h0000, r_q.fault};
        end
        default: begin
          if (map_hit) begin
            r_d.rdata = {12'h000, r_q.map[map_idx*4 +: 4]};
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Register
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r_q <= '0;
      r_q.profile <= iopim_pkg::iopim_profile_t'(iopim_pkg::PROFILE_RST);
      r_q.state <= iopim_pkg::iopim_st_config;
      for (int i = 0; i < 16; i++) begin
        r_q.map[i*4 +: 4] <= 4'(i);
      end
    end else begin
      r_q <= r_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata = r_q.rdata;
  assign pin4_target_states = r_q.tgt4;
  assign pin2_target_states = r_q.tgt2;
  assign image_in = r_q.img;
  assign ext_bits_to_ext = r_q.xbits;
  assign ext_words_to_ext = r_q.xwords;
  assign map_fault = r_q.fault;

endmodule : iopim_mapper
`default_nettype wire

// ### rtl/iopim_pkg.sv
// Package: profile codes, widths, register map and carriers for the mapper
package iopim_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned NUM_CONN = 8;
  localparam int unsigned NUM_CHAN = 16;
  localparam int unsigned EXT_WORDS = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // ****************************************************************
  // Channel profiles
  // ****************************************************************
  typedef enum logic [2:0] {
    sixteen_mixed_profile = 3'h0,
    eight_mixed_profile = 3'h1,
    sixteen_input_profile = 3'h2,
    eight_input_profile = 3'h3,
    sixteen_output_profile = 3'h4,
    eight_output_profile = 3'h5,
    split_in_out_profile = 3'h6
  } iopim_profile_t;

  typedef enum logic {
    iopim_st_config,
    iopim_st_cyclic
  } iopim_state_t;

  // ****************************************************************
  // Register map (word offsets)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h01;
  localparam logic [ADDR_W-1:0] REG_MAP_BASE = 8'h10;
  localparam int unsigned CTRL_PROF_LSB = 0;
  localparam int unsigned CTRL_REMAP_BIT = 3;
  localparam int unsigned CTRL_RUN_BIT = 4;
  localparam logic [2:0] PROFILE_RST = 3'h0;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [15:0] in_bytes;
    logic [15:0] ext_bits_in;
    logic [EXT_WORDS*WORD_W-1:0] ext_words_in;
  } iopim_image_in_t;

  typedef struct packed {
    logic [15:0] out_bytes;
    logic [15:0] ext_bits_out;
    logic [EXT_WORDS*WORD_W-1:0] ext_words_out;
  } iopim_image_out_t;

endpackage : iopim_pkg

// ### verif/iopim_ctrl_model.sv
// Partner: fieldbus controller sending the cyclic output image
`timescale 1ns/1ps
`default_nettype none
module iopim_ctrl_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Request from the bench
  input wire iopim_pkg::iopim_profile_t prof,
  input wire logic [15:0] bytes_req,
  input wire logic [15:0] bits_req,
  input wire logic [127:0] words_req,
  // Cyclic image to the device
  output iopim_pkg::iopim_image_out_t image_out
);
  logic [15:0] junk_q;
  // ****
  // Unsent bytes change every cycle
  // ****
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) junk_q <= 16'h0;
    else junk_q <= ~junk_q ^ 16'h1234;
  end
  always_comb begin
    image_out.ext_bits_out = bits_req;
    image_out.ext_words_out = words_req;
    case (prof)
      iopim_pkg::sixteen_mixed_profile,
      iopim_pkg::sixteen_output_profile: begin
        image_out.out_bytes = bytes_req;
      end
      iopim_pkg::eight_mixed_profile, iopim_pkg::eight_output_profile,
      iopim_pkg::split_in_out_profile: begin
        image_out.out_bytes = {junk_q[15:8], bytes_req[7:0]};
      end
      default: image_out.out_bytes = junk_q;
    endcase
  end
endmodule : iopim_ctrl_model
`default_nettype wire

// ### verif/iopim_mapper_assertions.sv
// Checker: port-level properties of the process image mapper
`timescale 1ns/1ps
`default_nettype none
module iopim_mapper_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Data paths
  input wire logic [7:0] pin4_target_states,
  input wire logic [7:0] pin2_target_states,
  input wire iopim_pkg::iopim_image_out_t image_out,
  input wire iopim_pkg::iopim_image_in_t image_in,
  input wire logic [15:0] ext_bits_from_ext,
  input wire logic [127:0] ext_words_from_ext,
  input wire logic [15:0] ext_bits_to_ext,
  input wire logic [127:0] ext_words_to_ext,
  input wire logic map_fault
);
  // ****
  // Settling after reset
  // ****
  logic [1:0] up_q;
  logic live;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  assign live = up_q == 2'h3;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0)
    else $error("read data not zero outside read slot");
  status_read_a: assert property (
    reg_rd && reg_addr == 8'h01 |=> reg_rdata == {15'h0, $past(map_fault)})
    else $error("status read does not show fault");
  unmapped_read_a: assert property (
    reg_rd && reg_addr == 8'h02 |=> reg_rdata == 16'h0)
    else $error("unmapped read not zero");
  ext_out_bits_a: assert property (
    live |=> ext_bits_to_ext == $past(image_out.ext_bits_out))
    else $error("extension bits not passed on");
  ext_out_words_a: assert property (
    live |=> ext_words_to_ext == $past(image_out.ext_words_out))
    else $error("extension words not passed on");
  ext_in_bits_a: assert property (
    live |=> image_in.ext_bits_in == $past(ext_bits_from_ext))
    else $error("extension bits not returned");
  ext_in_words_a: assert property (
    live |=> image_in.ext_words_in == $past(ext_words_from_ext))
    else $error("extension words not returned");
  fault_off_a: assert property (
    map_fault && $past(map_fault) |->
    {pin4_target_states, pin2_target_states} == 16'h0)
    else $error("targets driven while map fault");
  fault_seen_c: cover property (map_fault);
  run_write_c: cover property (reg_wr && reg_addr == 8'h00 && reg_wdata[4]);
  status_c: cover property (reg_rd && reg_addr == 8'h01 ##1 reg_rdata[0]);
endmodule : iopim_mapper_chk
`default_nettype wire

// ### verif/iopim_mapper_tb_top.sv
// Bench: profile sweep, extension paths and remap fault of the mapper
`timescale 1ns/1ps
`default_nettype none
module iopim_mapper_tb_top;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, ext_bits_to_ext, bits_req = 16'h0, bytes_req = 16'h0;
  logic [7:0] pin4_channel_states = 8'h00, pin2_channel_states = 8'h00;
  logic [7:0] pin4_target_states, pin2_target_states;
  logic [15:0] ext_bits_from_ext = 16'h0000;
  logic [127:0] ext_words_from_ext = 128'h0, words_req = 128'h0;
  logic [127:0] ext_words_to_ext;
  logic map_fault;
  iopim_pkg::iopim_profile_t prof = iopim_pkg::sixteen_mixed_profile;
  iopim_pkg::iopim_image_out_t image_out;
  iopim_pkg::iopim_image_in_t image_in;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  iopim_mapper u_iopim_mapper (.sys_clk, .rst_b, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .pin4_channel_states, .pin2_channel_states,
    .pin4_target_states, .pin2_target_states, .image_out, .image_in,
    .ext_bits_from_ext, .ext_words_from_ext, .ext_bits_to_ext,
    .ext_words_to_ext, .map_fault);
  iopim_ctrl_model u_iopim_ctrl_model (.sys_clk, .rst_b, .prof, .bytes_req,
    .bits_req, .words_req, .image_out);
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      finish_test();
    end
  end
  // ****
  // Helpers
  // ****
  function automatic logic [15:0] il(input logic [7:0] a, input logic [7:0] b);
    for (int c = 0; c < 8; c++) begin
      il[2*c] = a[c];
      il[2*c+1] = b[c];
    end
  endfunction : il
  function automatic logic [15:0] dl(input logic [15:0] o);
    for (int c = 0; c < 8; c++) begin
      dl[c] = o[2*c];
      dl[8+c] = o[2*c+1];
    end
  endfunction : dl
  task automatic chk(input string n, input logic [159:0] s, e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, e);
  endtask : rd
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  task automatic prof_run(input logic [2:0] p);
    logic [15:0] s, d8, ei, et;
    s = il(pin4_channel_states, pin2_channel_states);
    d8 = dl({8'h00, bytes_req[7:0]});
    ei = s;
    et = 16'h0000;
    case (p)
      3'h0, 3'h4: et = dl(bytes_req);
      3'h1: ei = {8'h00, pin4_channel_states};
      3'h3: ei = {8'h00, pin4_channel_states};
      3'h5, 3'h7: ei = 16'h0000;
      3'h6: ei = {8'h00, s[7:0]};
      default: et = 16'h0000;
    endcase
    if (p == 3'h1 || p == 3'h5) et = {8'h00, bytes_req[7:0]};
    if (p == 3'h6) et = {d8[11:8], 4'h0, d8[3:0], 4'h0};
    prof <= iopim_pkg::iopim_profile_t'(p);
    wr(8'h00, {11'h000, 2'h2, p});
    wr(8'h00, {11'h000, 2'h3, ~p});
    repeat (6) @(posedge sys_clk);
    rd(8'h00, {11'h000, 2'h2, p});
    chk("in_bytes", image_in.in_bytes, ei);
    chk("targets", {pin2_target_states, pin4_target_states}, et);
    wr(8'h00, {13'h0000, p});
  endtask : prof_run
  // ****
  // Main sequence
  // ****
  initial begin
    logic [15:0] sw;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(8'h00, 16'h0000);
    rd(8'h02, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      pin4_channel_states <= 8'hC3 ^ {8{k[0]}};
      pin2_channel_states <= 8'h96;
      bytes_req <= 16'hB4E1 ^ {16{k[0]}};
      bits_req <= 16'h5AA5 ^ {16{k[0]}};
      words_req <= 128'h0123456789ABCDEFFEDCBA9876543210 ^ {128{k[0]}};
      ext_bits_from_ext <= 16'hC0DE ^ {16{k[0]}};
      ext_words_from_ext <= 128'h1111222233334444AAAABBBBCCCCDDDD << k;
      @(posedge sys_clk);
      for (int p = 0; p < 8; p++) prof_run(p[2:0]);
      chk("ext_bits_in", image_in.ext_bits_in, ext_bits_from_ext);
      chk("ext_words_in", image_in.ext_words_in, ext_words_from_ext);
      chk("ext_bits_to", ext_bits_to_ext, bits_req);
      chk("ext_words_to", ext_words_to_ext, words_req);
    end
    prof <= iopim_pkg::sixteen_mixed_profile;
    wr(8'h10, 16'h0001);
    wr(8'h00, 16'h0018);
    rd(8'h01, 16'h0001);
    chk("targets", {pin2_target_states, pin4_target_states}, 16'h0);
    wr(8'h00, 16'h0000);
    wr(8'h10, 16'h0000);
    wr(8'h00, 16'h0018);
    rd(8'h01, 16'h0000);
    chk("targets", {pin2_target_states, pin4_target_states}, dl(bytes_req));
    wr(8'h10, 16'h000F);
    rd(8'h10, 16'h0000);
    wr(8'h00, 16'h0000);
    wr(8'h10, 16'h0001);
    wr(8'h11, 16'h0000);
    wr(8'h00, 16'h0018);
    repeat (4) @(posedge sys_clk);
    rd(8'h11, 16'h0000);
    rd(8'h01, 16'h0000);
    sw = il(pin4_channel_states, pin2_channel_states);
    chk("in_remap", image_in.in_bytes, {sw[15:2], sw[0], sw[1]});
    sw = bytes_req;
    chk("tgt_remap", {pin2_target_states, pin4_target_states},
      dl({sw[15:2], sw[0], sw[1]}));
    finish_test();
  end
endmodule : iopim_mapper_tb_top
bind iopim_mapper iopim_mapper_chk u_iopim_mapper_chk (.sys_clk, .rst_b,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin4_target_states,
  .pin2_target_states, .image_out, .image_in, .ext_bits_from_ext,
  .ext_words_from_ext, .ext_bits_to_ext, .ext_words_to_ext, .map_fault);
`default_nettype wire
